// >>> hw/host_micro_port_mode_select.sv
// Purpose: pin front end of the host microcontroller port
// Assumes: all pin inputs except masterRstN synchronous to clk_sys (50 MHz)
// Notes:   styles and strap are caught once after reset
//
// Summary of operation
// - select inputs 00 mux 8-bit, 01 direct, 10 mux 16-bit, 11 16-bit with wait
// - strap caught after reset release: high means legacy mode, low amended mode
// - in the direct and wait styles the strap pin becomes the wait output
// - upper address pins used in 16-bit mux and wait styles, ignored in mux 8-bit
// - data always on the 8-bit bus; low address from it when multiplexed
// - latch enable captures low address in mux and wait styles only
// - read and write strobes are separate and asserted only while low
// - interrupt pin pulled low when pending, released otherwise
// - master reset low resets everything at once, no clock needed
// - direct style stops driving data once select or read negates
// - mux styles enable data on read assert, take write data at write rise
// - direct style holds wait low during selected read until data ready
`include "host_micro_port_regs.svh"

module host_micro_port_mode_select (
  // clock, enable and resets
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        masterRstN,
  // straps
  input  wire logic [1:0]  hostSel,
  input  wire logic        strapIn,
  output logic             strapOut,
  output logic             strapOeN,
  // host strobes and address
  input  wire logic        csN,
  input  wire logic        rdN,
  input  wire logic        wrN,
  input  wire logic        ale,
  input  wire logic [7:0]  addrPins,
  // host data bus
  input  wire logic [7:0]  dataIn,
  output logic [7:0]       dataOut,
  output logic             dataOeN,
  // interrupt pin
  output logic             intOut,
  output logic             intOeN,
  // internal side
  input  wire logic        irqPending,
  input  wire logic [7:0]  rdData,
  input  wire logic        rdDataValid,
  output logic             accRead,
  output logic             accWrite,
  output logic [15:0]      accAddr,
  output logic [7:0]       accWrData,
  output logic             legacyMode,
  output logic [1:0]       hostStyle
);

  // =====================================================================
  // captured straps
  logic                             captured_reg;
  host_micro_port_pkg::host_style_t style_reg;
  logic                             legacy_reg;

  // strap is caught by the clock after release, never inside the reset
  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      captured_reg <= 1'b0;
      style_reg    <= host_micro_port_pkg::STYLE_MUX8;
      legacy_reg   <= 1'b0;
    end else if (sys_rst) begin
      captured_reg <= 1'b0;
      style_reg    <= host_micro_port_pkg::STYLE_MUX8;
      legacy_reg   <= 1'b0;
    end else if (clkEn && !captured_reg) begin
      captured_reg <= 1'b1;
      style_reg    <= host_micro_port_pkg::host_style_t'(hostSel);
      legacy_reg   <= strapIn;
    end
  end

  assign legacyMode = legacy_reg;
  assign hostStyle  = style_reg;

  // =====================================================================
  // style decode
  logic isDirect;
  logic useLatch;
  logic useUpper;
  logic hasWait;

  // later changes of the selects are not seen, by design
  always_comb begin
    isDirect = (style_reg == host_micro_port_pkg::STYLE_DIRECT);
    useLatch = !isDirect;
    useUpper = (style_reg == host_micro_port_pkg::STYLE_MUX16) ||
               (style_reg == host_micro_port_pkg::STYLE_WAIT16);
    hasWait  = isDirect || (style_reg == host_micro_port_pkg::STYLE_WAIT16);
  end

  // =====================================================================
  // strobes
  logic rdAct;
  logic wrAct;
  logic rdActQ;
  logic rdFall;
  logic wrRise;

  always_comb begin
    rdAct = ~csN & ~rdN;
    wrAct = ~csN & ~wrN;
  end

  strobe_edge u_rdEdge (
    .clk_sys    (clk_sys),
    .masterRstN (masterRstN),
    .sys_rst    (sys_rst),
    .clkEn      (clkEn),
    .level      (rdAct),
    .levelQ     (rdActQ),
    .rise       (),
    .fall       ()
  );

  strobe_edge u_wrEdge (
    .clk_sys    (clk_sys),
    .masterRstN (masterRstN),
    .sys_rst    (sys_rst),
    .clkEn      (clkEn),
    .level      (wrAct),
    .levelQ     (),
    .rise       (),
    .fall       (wrRise)
  );

  // read start seen one cycle earlier than a registered edge
  always_comb begin
    rdFall = rdAct & ~rdActQ;
  end

  // =====================================================================
  // address capture
  logic [7:0] addrLo_reg;

  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      addrLo_reg <= `HMP_RST_BYTE;
    end else if (sys_rst) begin
      addrLo_reg <= `HMP_RST_BYTE;
    end else if (clkEn && useLatch && ale) begin
      addrLo_reg <= dataIn;
    end
  end

  logic [15:0] addrNow;

  always_comb begin
    if (isDirect) begin
      addrNow = {8'h00, addrPins};
    end else if (useUpper) begin
      addrNow = {addrPins, addrLo_reg};
    end else begin
      addrNow = {8'h00, addrLo_reg};
    end
  end

  // =====================================================================
  // write path
  logic [7:0] wrHold_reg;

  // the last sample while low is the value present at the rising edge
  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      wrHold_reg <= `HMP_RST_BYTE;
      accWrite   <= 1'b0;
      accWrData  <= `HMP_RST_BYTE;
    end else if (sys_rst) begin
      wrHold_reg <= `HMP_RST_BYTE;
      accWrite   <= 1'b0;
      accWrData  <= `HMP_RST_BYTE;
    end else if (clkEn) begin
      if (wrAct) begin
        wrHold_reg <= dataIn;
      end
      accWrite <= wrRise & captured_reg;
      if (wrRise) begin
        accWrData <= wrHold_reg;
      end
    end
  end

  // =====================================================================
  // read sequencer
  host_micro_port_pkg::rd_state_t rdState_reg;
  host_micro_port_pkg::rd_state_t rdState_next;

  always_comb begin
    rdState_next = rdState_reg;
    case (rdState_reg)
      host_micro_port_pkg::RD_IDLE: begin
        if (rdFall && captured_reg) begin
          rdState_next = host_micro_port_pkg::RD_FETCH;
        end
      end
      host_micro_port_pkg::RD_FETCH: begin
        if (!rdAct) begin
          rdState_next = host_micro_port_pkg::RD_IDLE;
        end else if (rdDataValid) begin
          rdState_next = host_micro_port_pkg::RD_DRIVE;
        end
      end
      host_micro_port_pkg::RD_DRIVE: begin
        if (!rdAct) begin
          rdState_next = host_micro_port_pkg::RD_IDLE;
        end
      end
      default: begin
        rdState_next = host_micro_port_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      rdState_reg <= host_micro_port_pkg::RD_IDLE;
      accRead     <= 1'b0;
      accAddr     <= `HMP_RST_ADDR;
    end else if (sys_rst) begin
      rdState_reg <= host_micro_port_pkg::RD_IDLE;
      accRead     <= 1'b0;
      accAddr     <= `HMP_RST_ADDR;
    end else if (clkEn) begin
      rdState_reg <= rdState_next;
      accRead     <= rdFall & captured_reg & (rdState_reg == host_micro_port_pkg::RD_IDLE);
      if (rdFall || wrAct) begin
        accAddr <= addrNow;
      end
    end
  end

  // =====================================================================
  // data bus drive
  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      dataOut <= `HMP_RST_BYTE;
      dataOeN <= 1'b1;
    end else if (sys_rst) begin
      dataOut <= `HMP_RST_BYTE;
      dataOeN <= 1'b1;
    end else if (clkEn) begin
      if (rdDataValid && rdState_reg == host_micro_port_pkg::RD_FETCH) begin
        dataOut <= rdData;
      end
      // enabled on assert in every style; shows the old byte until fetched
      dataOeN <= ~(rdAct & captured_reg);
    end
  end

  // =====================================================================
  // wait output on the strap pin
  logic readPending;

  always_comb begin
    readPending = rdAct && (rdState_next != host_micro_port_pkg::RD_DRIVE);
  end

  // the pin only turns into an output once the strap has been caught
  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      strapOut <= 1'b1;
      strapOeN <= 1'b1;
    end else if (sys_rst) begin
      strapOut <= 1'b1;
      strapOeN <= 1'b1;
    end else if (clkEn) begin
      strapOeN <= ~(captured_reg & hasWait);
      strapOut <= ~(hasWait & readPending);
    end
  end

  // =====================================================================
  // interrupt pin
  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      intOut <= 1'b0;
      intOeN <= 1'b1;
    end else if (sys_rst) begin
      intOut <= 1'b0;
      intOeN <= 1'b1;
    end else if (clkEn) begin
      intOut <= 1'b0;
      intOeN <= ~irqPending;
    end
  end

endmodule

// >>> hw/strobe_edge.sv
// Purpose: registered level and edge pulses of one strobe
// Assumes: input is synchronous to clk_sys
// Notes:   async master reset forces constants only

module strobe_edge (
  // clock and resets
  input  wire logic clk_sys,
  input  wire logic masterRstN,
  input  wire logic sys_rst,
  input  wire logic clkEn,
  // strobe
  input  wire logic level,
  output logic      levelQ,
  output logic      rise,
  output logic      fall
);

  // =====================================================================
  // edge detection
  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      levelQ <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else if (sys_rst) begin
      levelQ <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else if (clkEn) begin
      levelQ <= level;
      rise   <= level & ~levelQ;
      fall   <= ~level & levelQ;
    end
  end

endmodule

// >>> include/host_micro_port_pkg.sv
// Purpose: types of the host port mode front end
// Assumes: host_micro_port_regs.svh supplies the codes
// Notes:   no constants of its own, only types
`include "host_micro_port_regs.svh"

package host_micro_port_pkg;

  // =====================================================================
  // bus style
  typedef enum logic [1:0] {
    STYLE_MUX8   = `HMP_STYLE_MUX8,
    STYLE_DIRECT = `HMP_STYLE_DIRECT,
    STYLE_MUX16  = `HMP_STYLE_MUX16,
    STYLE_WAIT16 = `HMP_STYLE_WAIT16
  } host_style_t;

  // =====================================================================
  // read sequencer
  typedef enum logic [2:0] {
    RD_IDLE  = `HMP_ST_IDLE,
    RD_FETCH = `HMP_ST_FETCH,
    RD_DRIVE = `HMP_ST_DRIVE
  } rd_state_t;

endpackage

// >>> include/host_micro_port_regs.svh
`ifndef HOST_MICRO_PORT_REGS_SVH
`define HOST_MICRO_PORT_REGS_SVH
// Purpose: constants of the host port mode front end
// Assumes: plain defines, included by bare name
// Notes:   style codes are the values seen on the two select inputs

// =====================================================================
// host style select codes
`define HMP_STYLE_MUX8   2'h0
`define HMP_STYLE_DIRECT 2'h1
`define HMP_STYLE_MUX16  2'h2
`define HMP_STYLE_WAIT16 2'h3

// =====================================================================
// reset values
`define HMP_RST_BYTE     8'h00
`define HMP_RST_ADDR     16'h0000
`define HMP_RST_STYLE    2'h0

// =====================================================================
// read sequencer one-hot codes
`define HMP_ST_IDLE      3'h1
`define HMP_ST_FETCH     3'h2
`define HMP_ST_DRIVE     3'h4

`endif

// >>> verif/host_micro_model.sv
// Purpose: external microcontroller driving the host port
// Assumes: style known from the select straps
// Notes:   a released data bus shows the inverse of its last value
module host_micro_model (
  // clock and status
  input wire logic       clk_sys,
  input wire logic [1:0] hostSel,
  input wire logic       waitPin,
  // data bus from device
  input wire logic [7:0] dataOut,
  input wire logic       dataOeN,
  // strobes and buses
  output logic           csN,
  output logic           rdN,
  output logic           wrN,
  output logic           ale,
  output logic [7:0]     addrPins,
  output logic [7:0]     dataIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       hostOe;
  logic [7:0] hostData;
  logic [7:0] lastBus;
  initial begin
    {csN, rdN, wrN, ale, hostOe} = 5'h1c;
    addrPins = 8'h00;
    hostData = 8'h00;
    lastBus = 8'h00;
  end
  assign dataIn = !dataOeN ? dataOut : hostOe ? hostData : ~lastBus;
  always @(posedge clk_sys) lastBus <= dataIn;
  task automatic setAddr(input logic [15:0] a, input logic sel);
    @(posedge clk_sys);
    ale <= hostSel != 2'h1;
    hostOe <= hostSel != 2'h1;
    hostData <= a[7:0];
    addrPins <= (hostSel == 2'h1) ? a[7:0] : a[15:8];
    @(posedge clk_sys);
    {ale, hostOe} <= 2'h0;
    csN <= ~sel;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    setAddr(a, 1'b1);
    @(posedge clk_sys);
    rdN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    for (int i = 0; i < 20 && hostSel[0] && !waitPin; i++) @(negedge clk_sys);
    d = dataIn;
    @(posedge clk_sys);
    {rdN, csN} <= 2'h3;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic sel);
    setAddr(a, sel);
    @(posedge clk_sys);
    {hostOe, wrN} <= 2'h2;
    hostData <= d;
    @(posedge clk_sys);
    wrN <= 1'b1;
    @(posedge clk_sys);
    {csN, hostOe} <= 2'h2;
  endtask
endmodule

// >>> verif/host_micro_port_asserts.sv
// Purpose: port checks of the host port front end
// Assumes: clkEn held high by the bench
// Notes:   sees only the top module ports
module host_micro_port_asserts (
  // clock and resets
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        masterRstN,
  // host side
  input wire logic        csN,
  input wire logic        rdN,
  input wire logic        wrN,
  input wire logic [7:0]  addrPins,
  input wire logic [7:0]  dataIn,
  input wire logic        dataOeN,
  input wire logic        strapOut,
  input wire logic        strapOeN,
  input wire logic        intOut,
  input wire logic        intOeN,
  // internal side
  input wire logic        irqPending,
  input wire logic        accRead,
  input wire logic        accWrite,
  input wire logic [15:0] accAddr,
  input wire logic [7:0]  accWrData,
  input wire logic [1:0]  hostStyle
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // reset shadow
  // outputs still hold reset values one edge after release, so skip that edge
  logic rstSeen_reg;
  always_ff @(posedge clk_sys or negedge masterRstN) begin
    if (!masterRstN) begin
      rstSeen_reg <= 1'b1;
    end else begin
      rstSeen_reg <= sys_rst;
    end
  end
  // ==================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || !masterRstN || rstSeen_reg);
  int_pull_a: assert property (irqPending |=> !intOeN && intOut == 1'b0)
    else $error("interrupt pin not pulled");
  int_free_a: assert property (!irqPending |=> intOeN)
    else $error("interrupt pin not released");
  data_hiz_a: assert property (!dataOeN |-> $past(!csN && !rdN))
    else $error("data driven outside a selected read");
  rd_take_a: assert property (accRead |-> $past(!csN && !rdN) && !dataOeN)
    else $error("read taken without strobes");
  wr_take_a: assert property (accWrite |-> $past(!csN && !wrN, 3) && $past(wrN, 2)
    && accWrData == $past(dataIn, 3))
    else $error("write not taken at strobe rise");
  wait_low_a: assert property (accRead && hostStyle[0] |-> !strapOeN && !strapOut)
    else $error("wait not asserted in read");
  wait_off_a: assert property (!hostStyle[0] |-> strapOeN)
    else $error("strap pin driven in mux style");
  wait_free_a: assert property (rdN |=> strapOut)
    else $error("wait held without a read");
  addr_mux8_a: assert property (accRead && hostStyle == 2'h0 |-> accAddr[15:8] == 8'h00)
    else $error("upper address used in mux 8-bit");
  addr_dir_a: assert property (accRead && hostStyle == 2'h1
    |-> accAddr == {8'h00, $past(addrPins)})
    else $error("direct address wrong");
  addr_hi_a: assert property (accRead && hostStyle[1] |-> accAddr[15:8] == $past(addrPins))
    else $error("upper address wrong");
endmodule

bind host_micro_port_mode_select host_micro_port_asserts u_chk (
  .clk_sys, .sys_rst, .masterRstN, .csN, .rdN, .wrN, .addrPins, .dataIn, .dataOeN,
  .strapOut, .strapOeN, .intOut, .intOeN, .irqPending, .accRead, .accWrite, .accAddr,
  .accWrData, .hostStyle
);

// >>> verif/host_micro_port_mode_select_tb.sv
// Purpose: self-checking bench of the host port front end
// Assumes: clkEn tied high
// Notes:   one reset per style, last one through the async pin
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", nm, e, g); n_mismatch++; end end
module host_micro_port_mode_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, sys_rst = 1, masterRstN = 0, strapPull = 0, irqPending = 0;
  logic rdDataValid = 0, csN, rdN, wrN, ale, strapIn, strapOut, strapOeN;
  logic dataOeN, intOut, intOeN, accRead, accWrite, legacyMode, gotWr;
  logic [1:0] hostSel = 2'h0, hostStyle;
  logic [7:0] rdData = 8'h00, addrPins, dataIn, dataOut, accWrData, d, wd;
  logic [15:0] accAddr, a;
  int n_mismatch = 0, compares = 0, cycles = 0;
  // ==================================================================
  // pins and internal answer
  assign strapIn = strapOeN ? strapPull : strapOut;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    rdDataValid <= accRead;
    rdData <= ~accAddr[7:0];
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      summarize();
    end
  end
  host_micro_port_mode_select u_dut (.clk_sys, .sys_rst, .clkEn(1'b1), .masterRstN,
    .hostSel, .strapIn, .strapOut, .strapOeN, .csN, .rdN, .wrN, .ale, .addrPins,
    .dataIn, .dataOut, .dataOeN, .intOut, .intOeN, .irqPending, .rdData, .rdDataValid,
    .accRead, .accWrite, .accAddr, .accWrData, .legacyMode, .hostStyle);
  host_micro_model u_host (.clk_sys, .hostSel, .waitPin(strapIn), .dataOut, .dataOeN,
    .csN, .rdN, .wrN, .ale, .addrPins, .dataIn);
  task automatic summarize;
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // accWrite is a one-cycle pulse, so poll every cycle
  task automatic waitWr;
    gotWr = 1'b0;
    repeat (6) begin
      @(negedge clk_sys);
      if (accWrite === 1'b1) begin
        gotWr = 1'b1;
        wd = accWrData;
      end
    end
  endtask
  // ==================================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_sys);
    {sys_rst, masterRstN} <= 2'h1;
    for (int s = 0; s < 4; s++) begin
      irqPending <= s[0];
      hostSel <= s[1:0];
      strapPull <= s[1];
      repeat (2) @(posedge clk_sys);
      if (s == 3) begin
        #3 masterRstN = 1'b0;
        #1 `CHK("asyncStyle", 2'h0, hostStyle)
        `CHK("asyncInt", 1'b1, intOeN)
        @(posedge clk_sys) masterRstN <= 1'b1;
      end else begin
        sys_rst <= 1'b1;
        @(posedge clk_sys) sys_rst <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("style", s[1:0], hostStyle)
      `CHK("legacy", s[1], legacyMode)
      `CHK("waitOe", ~s[0], strapOeN)
      `CHK("intOe", ~s[0], intOeN)
      a = {6'h2d, s[1:0], 6'h17, ~s[1:0]};
      u_host.rd(a, d);
      `CHK("rdAddr", s[1] ? a : {8'h00, a[7:0]}, accAddr)
      `CHK("rdData", ~a[7:0], d)
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK("release", 1'b1, dataOeN)
      u_host.wr(a ^ 16'h0f0f, a[15:8], 1'b1);
      waitWr();
      `CHK("wr", 1'b1, gotWr)
      `CHK("wrData", a[15:8], wd)
      u_host.wr(a, 8'h00, 1'b0);
      waitWr();
      `CHK("wrNoCs", 1'b0, gotWr)
    end
    summarize();
  end
endmodule
